// ==== src/cfb_defines.vh ====
// Purpose: constants for the code fetch bus and pointer select block
// Assumes: clk is the CPU clock, one bus cycle is six of its periods
// Notes:   included by its bare name
`ifndef CFB_DEFINES_VH
`define CFB_DEFINES_VH

// ************
// Register map
// ************
`define CFB_AUX_ADDR     8'hA2
`define CFB_DPS_BIT      0
`define CFB_ZERO_BIT     2
`define CFB_GF_BIT       3
`define CFB_BOOT_FLASH_MAP_ENABLE_BIT   5
`define CFB_AUX_DPS_RST  1'h0
`define CFB_AUX_GF_RST   1'h0

// ************
// Code space map
// ************
`define CFB_INT_TOP      16'h7FFF
`define CFB_BOOT_BASE    16'hF800

// ************
// Bus cycle phases and strap settle counts
// ************
`define CFB_PH_ALE       3'h0
`define CFB_PH_HOLD      3'h1
`define CFB_PH_STROBE    3'h2
`define CFB_PH_WAIT1     3'h3
`define CFB_PH_WAIT2     3'h4
`define CFB_PH_LAST      3'h5
`define CFB_STRAP_WAIT   2'h3
`define CFB_STRAP_TAKE   2'h2

`endif

// ==== src/cfb_code_fetch_bus.v ====
// Purpose: code fetch bus, dual data pointers and aux control register
// Assumes: bus pins and strap come from outside and are synchronised
// Notes:   one external bus cycle is six clk periods
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`include "cfb_defines.vh"

module cfb_code_fetch_bus (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire        reg_inc,
  output reg  [7:0]  reg_rdata,
  input  wire        bootloader_jump_setting,
  input  wire        dp_wr,
  input  wire        dp_inc,
  input  wire [15:0] dp_wdata,
  output reg  [15:0] data_pointer,
  input  wire        fetch_req,
  input  wire [15:0] fetch_addr,
  input  wire        code_constant_read,
  output reg         fetch_busy,
  output reg         fetch_done,
  output reg         fetch_internal,
  output reg         fetch_boot,
  output reg  [7:0]  fetch_data,
  input  wire [7:0]  muxed_low_addr_data_in,
  output reg  [7:0]  muxed_low_addr_data_out,
  output reg         muxed_low_addr_data_oe,
  output reg  [7:0]  high_address_lines,
  output reg         addr_latch_strobe,
  output reg         program_store_strobe_n
);

  // ************
  // Helpers
  // ************

  // Byte view of the aux register, reserved bits as zero
  function [7:0] cfb_aux_byte;
    input pointer_select_bit;
    input gf;
    input enb;
    begin
      cfb_aux_byte = 8'h00;
      cfb_aux_byte[`CFB_DPS_BIT]    = pointer_select_bit;
      cfb_aux_byte[`CFB_GF_BIT]     = gf;
      cfb_aux_byte[`CFB_BOOT_FLASH_MAP_ENABLE_BIT] = enb;
      cfb_aux_byte[`CFB_ZERO_BIT]   = 1'b0;
    end
  endfunction

  // ************
  // State
  // ************

  // Aux register fields
  reg        pointer_select_bit_reg;
  reg        user_general_flag_reg;
  reg        boot_flash_map_enable_reg;

  // Strap synchroniser and settle count
  reg [1:0]  strap_cnt_reg;
  reg        strap_s1_reg;
  reg        strap_s2_reg;

  // Pointer pair
  reg [15:0] first_data_pointer_reg;
  reg [15:0] second_data_pointer_reg;

  // Returning byte synchroniser
  reg [7:0]  pin_s1_reg;
  reg [7:0]  pin_s2_reg;

  // Bus cycle sequencer
  reg        bus_active_reg;
  reg [2:0]  phase_reg;
  reg        prefetch_only_reg;

  // Decode and handshake terms
  wire [7:0] aux_byte;
  wire [7:0] aux_inc;
  wire       aux_hit;
  wire       in_boot;
  wire       in_int;
  wire       need_bus;
  wire       start;

  // Register byte as software reads it
  assign aux_byte = cfb_aux_byte(pointer_select_bit_reg, user_general_flag_reg,
                                 boot_flash_map_enable_reg);
  // Bit 1 held at zero stops the carry reaching the flag
  assign aux_inc  = aux_byte + 8'h01;
  // Only one register answers on the bus
  assign aux_hit  = (reg_addr == `CFB_AUX_ADDR);

  // Code space regions, boot flash only while mapped
  assign in_boot  = boot_flash_map_enable_reg &&
                    (fetch_addr >= `CFB_BOOT_BASE);
  assign in_int   = (fetch_addr <= `CFB_INT_TOP);
  // Top on-chip address prefetches externally unless constant read
  assign need_bus = (!in_int && !in_boot) ||
                    (fetch_addr == `CFB_INT_TOP && !code_constant_read);

  // New request taken only while no bus cycle runs
  assign start    = fetch_req && !fetch_busy;

  // ************
  // Aux control register
  // ************

  // Strap synchroniser and settle count
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_cnt_reg <= 2'h0;
      strap_s1_reg  <= 1'b0;
      strap_s2_reg  <= 1'b0;
    end else begin
      strap_s1_reg <= bootloader_jump_setting;
      strap_s2_reg <= strap_s1_reg;
      if (strap_cnt_reg != `CFB_STRAP_WAIT) begin
        // Count saturates so the strap loads once
        strap_cnt_reg <= strap_cnt_reg + 2'h1;
      end
    end
  end

  // Write, increment and strap capture
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pointer_select_bit_reg    <= `CFB_AUX_DPS_RST;
      user_general_flag_reg     <= `CFB_AUX_GF_RST;
      boot_flash_map_enable_reg <= 1'b0;
    end else begin
      if (reg_wr && aux_hit) begin
        pointer_select_bit_reg    <= reg_wdata[`CFB_DPS_BIT];
        user_general_flag_reg     <= reg_wdata[`CFB_GF_BIT];
        boot_flash_map_enable_reg <= reg_wdata[`CFB_BOOT_FLASH_MAP_ENABLE_BIT];
      end else if (reg_inc) begin
        // Toggle relative to old value, flag kept
        pointer_select_bit_reg    <= aux_inc[`CFB_DPS_BIT];
        user_general_flag_reg     <= aux_inc[`CFB_GF_BIT];
        boot_flash_map_enable_reg <= aux_inc[`CFB_BOOT_FLASH_MAP_ENABLE_BIT];
      end else if (strap_cnt_reg == `CFB_STRAP_TAKE) begin
        // Boot enable loads from the synchronised strap
        boot_flash_map_enable_reg <= strap_s2_reg;
      end
    end
  end

  // Read data one cycle after the strobe
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd && aux_hit) begin
      reg_rdata <= aux_byte;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ************
  // Data pointers
  // ************

  // Load or step the selected pointer, present it
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      first_data_pointer_reg  <= 16'h0000;
      second_data_pointer_reg <= 16'h0000;
      data_pointer            <= 16'h0000;
    end else begin
      if (!pointer_select_bit_reg) begin
        if (dp_wr) begin
          first_data_pointer_reg <= dp_wdata;
        end else if (dp_inc) begin
          first_data_pointer_reg <= first_data_pointer_reg + 16'h0001;
        end
      end else begin
        if (dp_wr) begin
          second_data_pointer_reg <= dp_wdata;
        end else if (dp_inc) begin
          second_data_pointer_reg <= second_data_pointer_reg + 16'h0001;
        end
      end
      // Output follows the select bit a cycle late
      data_pointer <= pointer_select_bit_reg ? second_data_pointer_reg
                                             : first_data_pointer_reg;
    end
  end

  // ************
  // Pin synchroniser
  // ************

  // Two stages on the returning data byte
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_reg <= 8'h00;
      pin_s2_reg <= 8'h00;
    end else begin
      pin_s1_reg <= muxed_low_addr_data_in;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // ************
  // Fetch sequencer
  // ************

  // Internal fetch in one cycle, external in six phases
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_active_reg          <= 1'b0;
      phase_reg               <= `CFB_PH_ALE;
      prefetch_only_reg       <= 1'b0;
      fetch_busy              <= 1'b0;
      fetch_done              <= 1'b0;
      fetch_internal          <= 1'b0;
      fetch_boot              <= 1'b0;
      fetch_data              <= 8'h00;
      // Port released, latch low, strobe high
      muxed_low_addr_data_out <= 8'h00;
      muxed_low_addr_data_oe  <= 1'b0;
      high_address_lines      <= 8'h00;
      addr_latch_strobe       <= 1'b0;
      program_store_strobe_n  <= 1'b1;
    end else begin
      fetch_done <= 1'b0;
      if (start && !need_bus) begin
        // On-chip or boot space, ports left alone
        fetch_done     <= 1'b1;
        fetch_internal <= 1'b1;
        fetch_boot     <= in_boot;
      end else if (start) begin
        // Address out with latch pulse
        bus_active_reg          <= 1'b1;
        fetch_busy              <= 1'b1;
        phase_reg               <= `CFB_PH_HOLD;
        prefetch_only_reg       <= in_int;
        muxed_low_addr_data_out <= fetch_addr[7:0];
        muxed_low_addr_data_oe  <= 1'b1;
        high_address_lines      <= fetch_addr[15:8];
        addr_latch_strobe       <= 1'b1;
      end else if (bus_active_reg) begin
        case (phase_reg)
          `CFB_PH_HOLD: begin
            // Address held while the latch closes
            addr_latch_strobe <= 1'b0;
            phase_reg         <= `CFB_PH_STROBE;
          end
          `CFB_PH_STROBE: begin
            // Release low port, memory drives data
            muxed_low_addr_data_oe <= 1'b0;
            program_store_strobe_n <= 1'b0;
            phase_reg              <= phase_reg + 3'h1;
          end
          `CFB_PH_LAST: begin
            // Sample data, strobe rises, cycle ends
            program_store_strobe_n <= 1'b1;
            bus_active_reg         <= 1'b0;
            fetch_busy             <= 1'b0;
            fetch_done             <= 1'b1;
            fetch_internal         <= prefetch_only_reg;
            fetch_boot             <= 1'b0;
            fetch_data             <= pin_s2_reg;
            phase_reg              <= `CFB_PH_ALE;
          end
          `CFB_PH_WAIT1, `CFB_PH_WAIT2: begin
            // Strobe held low while the byte settles
            phase_reg <= phase_reg + 3'h1;
          end
          default: begin
            // Stray code, drop the cycle and free the port
            bus_active_reg         <= 1'b0;
            fetch_busy             <= 1'b0;
            addr_latch_strobe      <= 1'b0;
            muxed_low_addr_data_oe <= 1'b0;
            program_store_strobe_n <= 1'b1;
            phase_reg              <= `CFB_PH_ALE;
          end
        endcase
      end
    end
  end

endmodule

// ==== verif/cfb_code_fetch_bus_assertions.sv ====
// Purpose: bus timing checks
// Assumes: one clock, async low reset
// Notes:   bound below
`timescale 1ns/1ps
module cfb_code_fetch_bus_assertions (
  input logic        clk,
  input logic        rst_n,
  input logic [7:0]  reg_rdata,
  input logic        fetch_req,
  input logic [15:0] fetch_addr,
  input logic        code_constant_read,
  input logic        fetch_busy,
  input logic        fetch_done,
  input logic [7:0]  muxed_low_addr_data_out,
  input logic        muxed_low_addr_data_oe,
  input logic [7:0]  high_address_lines,
  input logic        addr_latch_strobe,
  input logic        program_store_strobe_n
);
  // ****
  // Checks
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Request taken while idle
  sequence s_take;
    fetch_req && !fetch_busy;
  endsequence
  // Port released, strobe low three cycles
  sequence s_strobe;
    (!program_store_strobe_n && !muxed_low_addr_data_oe) [*3] ##1 program_store_strobe_n;
  endsequence
  a_strobe_in_cycle: assert property (!program_store_strobe_n |-> fetch_busy)
    else $error("strobe outside cycle");
  a_latch_with_addr: assert property (addr_latch_strobe |-> muxed_low_addr_data_oe && program_store_strobe_n)
    else $error("latch without address");
  a_fetch_phases: assert property ($rose(addr_latch_strobe) |=> !addr_latch_strobe ##1 s_strobe)
    else $error("bad phase order");
  a_cycle_six: assert property ($rose(fetch_busy) |-> fetch_busy [*5] ##1 (fetch_done && !fetch_busy))
    else $error("bus cycle length");
  a_addr_phase: assert property ($rose(addr_latch_strobe) |-> {high_address_lines, muxed_low_addr_data_out} == $past(fetch_addr))
    else $error("wrong address");
  a_internal_quiet: assert property (s_take ##0 fetch_addr < 16'h7FFF |=> fetch_done && !fetch_busy)
    else $error("bus used on chip");
  a_constant_top: assert property (s_take ##0 code_constant_read && fetch_addr == 16'h7FFF |=> fetch_done && !fetch_busy)
    else $error("top read disturbed");
  a_fetch_top: assert property (s_take ##0 !code_constant_read && fetch_addr == 16'h7FFF |=> addr_latch_strobe)
    else $error("no top prefetch");
  a_bit2_zero: assert property (reg_rdata[2] == 1'b0)
    else $error("bit 2 set");
endmodule
bind cfb_code_fetch_bus cfb_code_fetch_bus_assertions cfb_code_fetch_bus_assertions_i (.clk, .rst_n, .reg_rdata,
  .fetch_req, .fetch_addr, .code_constant_read, .fetch_busy, .fetch_done, .muxed_low_addr_data_out,
  .muxed_low_addr_data_oe, .high_address_lines, .addr_latch_strobe, .program_store_strobe_n);

// ==== verif/cfb_program_memory.sv ====
// Purpose: external program memory with latch
// Assumes: byte is low ^ high address ^ 3C
// Notes:   undriven port shows a changing pattern
`timescale 1ns/1ps
module cfb_program_memory (
  input  logic       clk,
  input  logic [7:0] muxed_low_addr_data_out,
  input  logic       muxed_low_addr_data_oe,
  input  logic [7:0] high_address_lines,
  input  logic       addr_latch_strobe,
  input  logic       program_store_strobe_n,
  output logic [7:0] low_bus
);
  // ****
  // Latch and array
  // ****
  logic [7:0] low_latch = 8'h00;
  logic [7:0] last_level = 8'h00;
  // Capture low address during latch pulse
  always @(posedge clk) begin
    if (addr_latch_strobe) begin
      low_latch <= low_bus;
    end
    last_level <= low_bus;
  end
  // Drive byte only while store strobe low
  assign low_bus = muxed_low_addr_data_oe ? muxed_low_addr_data_out :
                   !program_store_strobe_n ? (low_latch ^ high_address_lines ^ 8'h3C) : ~last_level;
endmodule

// ==== verif/cfb_code_fetch_bus_test.sv ====
// Purpose: self-checking bench
// Assumes: memory model on the bus ports
// Notes:   register and fetch tasks
`timescale 1ns/1ps
module cfb_code_fetch_bus_test;
  // ****
  // Signals
  // ****
  logic        clk = 1'b0, rst_n = 1'b0, bootloader_jump_setting = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        reg_inc = 1'b0, dp_wr = 1'b0, dp_inc = 1'b0, fetch_req = 1'b0, code_constant_read = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, fetch_data, high_address_lines;
  logic [7:0]  muxed_low_addr_data_in, muxed_low_addr_data_out;
  logic [15:0] dp_wdata = 16'h0000, fetch_addr = 16'h0000, data_pointer;
  logic        fetch_busy, fetch_done, fetch_internal, fetch_boot, muxed_low_addr_data_oe;
  logic        addr_latch_strobe, program_store_strobe_n;
  int          fail_count = 0, samples_checked = 0, cycles = 0;
  cfb_code_fetch_bus cfb_code_fetch_bus_i (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_inc,
    .reg_rdata, .bootloader_jump_setting, .dp_wr, .dp_inc, .dp_wdata, .data_pointer, .fetch_req, .fetch_addr,
    .code_constant_read, .fetch_busy, .fetch_done, .fetch_internal, .fetch_boot, .fetch_data,
    .muxed_low_addr_data_in, .muxed_low_addr_data_out, .muxed_low_addr_data_oe, .high_address_lines,
    .addr_latch_strobe, .program_store_strobe_n);
  cfb_program_memory cfb_program_memory_i (.clk, .muxed_low_addr_data_out, .muxed_low_addr_data_oe,
    .high_address_lines, .addr_latch_strobe, .program_store_strobe_n, .low_bus(muxed_low_addr_data_in));
  // ****
  // Tasks
  // ****
  // Pointer word compare
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: pointer %h want %h", $time, got, exp);
    end
  endtask
  // Register or fetched byte compare
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: byte %h want %h", $time, got, exp);
    end
  endtask
  // Fetch source flags compare
  task automatic check_flags(input logic [1:0] got, input logic [1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: flags %h want %h", $time, got, exp);
    end
  endtask
  // Clocks from take edge to done compare
  task automatic check_cycles(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: cycles %0d want %0d", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checked %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Kind 0 write, 1 increment, 2 read and compare
  task automatic reg_op(input int kind, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= (kind == 0);
    reg_inc <= (kind == 1);
    reg_rd <= (kind == 2);
    @(posedge clk);
    {reg_wr, reg_inc, reg_rd} <= 3'h0;
    @(negedge clk);
    if (kind == 2) check_byte(reg_rdata, d);
  endtask
  task automatic dp_op(input logic w, input logic [15:0] v);
    @(posedge clk);
    dp_wr <= w;
    dp_inc <= !w;
    dp_wdata <= v;
    @(posedge clk);
    {dp_wr, dp_inc} <= 2'h0;
    repeat (2) @(negedge clk);
  endtask
  // Kind bit 1 on chip, bit 0 boot region; c clocks from take to done
  task automatic fetch(input logic [15:0] a, input logic m, input logic [1:0] k, input logic [7:0] c);
    logic [7:0] n;
    @(posedge clk);
    fetch_addr <= a;
    code_constant_read <= m;
    fetch_req <= 1'b1;
    @(posedge clk);
    fetch_req <= 1'b0;
    n = 8'h00;
    do begin @(negedge clk); n++; end while (fetch_done !== 1'b1 && n < 8'h14);
    check_cycles(n, c);
    check_flags({fetch_internal, fetch_boot}, k);
    if (!k[1]) check_byte(fetch_data, a[7:0] ^ a[15:8] ^ 8'h3C);
  endtask
  // ****
  // Clock, timeout, tests
  // ****
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    reg_op(2, 8'hA2, 8'h20);
    fetch(16'hF900, 1'b0, 2'h3, 8'h01);
    fetch(16'h1000, 1'b0, 2'h2, 8'h01);
    fetch(16'h7FFF, 1'b1, 2'h2, 8'h01);
    fetch(16'h7FFF, 1'b0, 2'h2, 8'h06);
    fetch(16'h8123, 1'b0, 2'h0, 8'h06);
    fetch(16'h9000, 1'b1, 2'h0, 8'h06);
    reg_op(0, 8'hA2, 8'h0D);
    reg_op(2, 8'hA2, 8'h09);
    fetch(16'hF900, 1'b0, 2'h0, 8'h06);
    reg_op(1, 8'hA2, 8'h00);
    reg_op(2, 8'hA2, 8'h08);
    reg_op(1, 8'hA2, 8'h00);
    reg_op(2, 8'hA2, 8'h09);
    reg_op(2, 8'hA3, 8'h00);
    reg_op(0, 8'hA3, 8'h21);
    reg_op(2, 8'hA2, 8'h09);
    dp_op(1'b1, 16'h1234);
    reg_op(1, 8'hA2, 8'h00);
    dp_op(1'b1, 16'hABCD);
    dp_op(1'b0, 16'h0000);
    check(data_pointer, 16'hABCE);
    reg_op(1, 8'hA2, 8'h00);
    repeat (2) @(negedge clk);
    check(data_pointer, 16'h1234);
    @(posedge clk);
    rst_n <= 1'b0;
    bootloader_jump_setting <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    reg_op(2, 8'hA2, 8'h00);
    give_verdict();
  end
endmodule
